// >>> test/internal_ram_test_data_port_tb.sv
`timescale 1ns/1ps
module internal_ram_test_data_port_tb;
  reg i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0000_0000;
  wire [31:0] o_rdata;
  wire o_test_mode, o_port_ready;
  integer n_fail = 0, tests_run = 0, cyc = 0, s, k, w;
  ram_test_port #(.DEPTH(256), .AW(8)) uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_test_mode(o_test_mode), .o_port_ready(o_port_ready));
  // 200 mhz clock
  initial forever #2.5 i_clk_sys = ~i_clk_sys;
  // ----------
  // bus tasks
  // ----------
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
    end
  endtask
  // read data only stands in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(negedge i_clk_sys);
      chk($sformatf("reg_%h", a), e, o_rdata);
    end
  endtask
  task tally_and_finish;
    begin
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // hang guard, run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(8'h40, 32'h8000_0000);
    rd(8'h44, 32'h0000_0000);
    rd(8'h48, 32'h0000_0000);
    rd(8'h4c, 32'h0000_0000);
    rd(8'h50, 32'h0000_0000);
    rd(8'h54, 32'h0000_0000);
    wr(8'h48, 32'hffff_ffff);
    rd(8'h48, 32'h0000_7fff);
    wr(8'h50, 32'hffff_ffff);
    rd(8'h50, 32'h0000_001f);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h8000_0007);
    chk("test_mode", 32'h0000_0001, {31'h0, o_test_mode});
    // same addresses in every ram, so a wrong selector shows
    for (s = 0; s < 4; s = s + 1) begin
      wr(8'h40, s * 2 + 1);
      for (k = 0; k < 2; k = k + 1) begin
        wr(8'h48, k * 255);
        wr(8'h4c, 32'hc3a5_0000 + s * 256 + k);
        wr(8'h50, s + k * 8 + 16);
        wr(8'h44, 32'h0000_0001);
        rd(8'h44, 32'h0000_0001);
      end
    end
    for (s = 0; s < 4; s = s + 1) begin
      wr(8'h40, s * 2 + 1);
      for (k = 0; k < 2; k = k + 1) begin
        wr(8'h48, k * 255);
        wr(8'h4c, 32'hffff_ffff);
        wr(8'h50, 32'hffff_ffff);
        wr(8'h44, 32'h0000_0000);
        rd(8'h40, s * 2 + 1);
        w = 0;
        // poll ready before fetching the result
        while (o_port_ready !== 1'b1 && w < 20) begin
          @(negedge i_clk_sys);
          w = w + 1;
        end
        chk("port_ready", 32'h0000_0001, {31'h0, o_port_ready});
        chk("ready_wait", 32'h0000_0001, w);
        rd(8'h4c, 32'hc3a5_0000 + s * 256 + k);
        rd(8'h50, (s > 1) ? s + k * 8 + 16 : 0);
      end
    end
    // with test mode off a command must leave the rams alone
    wr(8'h40, 32'h0000_0000);
    wr(8'h48, 32'h0000_0000);
    wr(8'h4c, 32'h1234_5678);
    wr(8'h44, 32'h0000_0001);
    chk("test_mode", 32'h0000_0000, {31'h0, o_test_mode});
    wr(8'h40, 32'h0000_0001);
    wr(8'h44, 32'h0000_0000);
    repeat (4) @(posedge i_clk_sys);
    rd(8'h4c, 32'hc3a5_0000);
    tally_and_finish;
  end
endmodule // internal_ram_test_data_port_tb

// >>> test/ram_test_port_chk.sv
`timescale 1ns/1ps
// ----------
// port checker
// ----------
module ram_test_port_chk #(parameter DEPTH = 256, parameter AW = 8) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire o_test_mode,
  input wire o_port_ready
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // busy command writes start no access, so only idle ones count
  wire cw = i_wr && i_addr == 8'h44 && o_port_ready;
  wire sw = i_wr && i_addr == 8'h40;
  property p_idle; !$past(i_rd) |-> o_rdata == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("rdata idle");
  property p_tm; sw ##1 !sw |=> o_test_mode == $past(i_wdata[0], 2); endproperty
  a_tm: assert property (p_tm) else $error("test mode");
  property p_wr; cw && i_wdata[0] |=> !o_port_ready ##1 o_port_ready; endproperty
  a_wr: assert property (p_wr) else $error("write busy");
  property p_rd; cw && !i_wdata[0] |=> !o_port_ready [*3] ##1 o_port_ready; endproperty
  a_rd: assert property (p_rd) else $error("read busy");
  property p_hold; o_port_ready && !cw |=> o_port_ready; endproperty
  a_hold: assert property (p_hold) else $error("ready drop");
  property p_sel; i_rd && i_addr == 8'h40 |=> o_rdata[31] == $past(o_port_ready); endproperty
  a_sel: assert property (p_sel) else $error("ready bit");
  property p_adr; i_rd && i_addr == 8'h48 |=> o_rdata[31:15] == 17'h0_0000; endproperty
  a_adr: assert property (p_adr) else $error("addr field");
  property p_hi; i_rd && i_addr == 8'h50 |=> o_rdata[31:5] == 27'h000_0000; endproperty
  a_hi: assert property (p_hi) else $error("high field");
  c_wr: cover property (cw && i_wdata[0]);
  c_rd: cover property (cw && !i_wdata[0]);
  c_poll: cover property (!o_port_ready && i_rd && i_addr == 8'h40);
  c_off: cover property (cw && !o_test_mode);
endmodule // ram_test_port_chk

bind ram_test_port ram_test_port_chk #(.DEPTH(DEPTH), .AW(AW)) u_chk (.i_clk_sys(i_clk_sys),
  .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_test_mode(o_test_mode), .o_port_ready(o_port_ready));

// >>> verilog/ram_bank.v
`timescale 1ns/1ps
`include "ram_port_map.vh"
// ----------------------------------------
// four test-accessible rams behind one port
// ----------------------------------------
module ram_bank #(
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire i_clk_sys,
  input wire i_test_mode,
  input wire i_en,
  input wire i_wr,
  input wire [1:0] i_sel,
  input wire [AW-1:0] i_addr,
  input wire [36:0] i_wdata,
  output wire [36:0] o_rdata
);
  wire [31:0] rd_fct;
  wire [31:0] rd_eep;
  wire [36:0] rd_tx;
  wire [36:0] rd_rx;
  reg [1:0] sel_q;

  // enables gated by test mode so no stray access in normal run
  wire en_ok = i_en & i_test_mode;

  test_ram #(.WIDTH(32), .DEPTH(DEPTH), .AW(AW)) u_fct (
    .i_clk_sys(i_clk_sys), .i_en(en_ok && i_sel == `SEL_FRAME_CTRL), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata[31:0]), .o_rdata(rd_fct));
  test_ram #(.WIDTH(32), .DEPTH(DEPTH), .AW(AW)) u_eep (
    .i_clk_sys(i_clk_sys), .i_en(en_ok && i_sel == `SEL_EEPROM), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata[31:0]), .o_rdata(rd_eep));
  test_ram #(.WIDTH(37), .DEPTH(DEPTH), .AW(AW)) u_tx (
    .i_clk_sys(i_clk_sys), .i_en(en_ok && i_sel == `SEL_TX_STAGE), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(rd_tx));
  test_ram #(.WIDTH(37), .DEPTH(DEPTH), .AW(AW)) u_rx (
    .i_clk_sys(i_clk_sys), .i_en(en_ok && i_sel == `SEL_RX_STAGE), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(rd_rx));

  // remember which ram answered for the output mux
  always @(posedge i_clk_sys) begin
    if (i_en) begin
      sel_q <= i_sel;
    end
  end

  // narrow rams read zero in the top five bits
  assign o_rdata = (sel_q == `SEL_FRAME_CTRL) ? {5'h00, rd_fct} :
                   (sel_q == `SEL_EEPROM) ? {5'h00, rd_eep} :
                   (sel_q == `SEL_TX_STAGE) ? rd_tx : rd_rx;
endmodule // ram_bank

// >>> verilog/ram_port_map.vh
// Overview of operation
// - test enable puts RAMs in test mode
// - selector bits 2:1 pick one of four RAMs
// - ready flag bit 31, busy 0, reset 1
// - read ready only after data captured
// - command write starts access, bit0 direction
// - address register 15-bit dword address, reset zero
// - low data register holds word bits 31:0
// - staging RAMs 37 bits, high register 4:0
`ifndef RAM_PORT_MAP_VH
`define RAM_PORT_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_SELECT 8'h40
`define OFS_COMMAND 8'h44
`define OFS_ADDRESS 8'h48
`define OFS_DATA_LOW 8'h4c
`define OFS_DATA_HIGH 8'h50
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BIT_TEST_EN 0
`define BIT_SEL_LO 1
`define BIT_SEL_HI 2
`define BIT_READY 31
`define BIT_CMD_WRITE 0
`define ADDR_MSB 14
`define HIGH_MSB 4
`define RST_SELECT 3'h0
`define RST_ADDRESS 15'h0000
`define RST_DATA_LOW 32'h0000_0000
`define RST_DATA_HIGH 5'h00
// ----------------------------------------
// ram selector codes
// ----------------------------------------
`define SEL_FRAME_CTRL 2'h0
`define SEL_EEPROM 2'h1
`define SEL_TX_STAGE 2'h2
`define SEL_RX_STAGE 2'h3
// ----------------------------------------
// timing: ram read latency in cycles
// ----------------------------------------
`define RAM_READ_LAT 2
`endif

// >>> verilog/ram_test_port.v
`timescale 1ns/1ps
`include "ram_port_map.vh"
// ----------------------------------------
// indirect ram test data port, top level
// ----------------------------------------
module ram_test_port #(
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output reg o_test_mode,
  output reg o_port_ready
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_ACCESS = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_CAPTURE = 2'd3;

  reg [2:0] select_ff;
  reg cmd_write_ff;
  reg [`ADDR_MSB:0] address_ff;
  reg [31:0] data_low_ff;
  reg [`HIGH_MSB:0] data_high_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg ram_en;
  wire [36:0] ram_rdata;

  // decoder for the write and command paths; the read mux decodes i_addr in its own case
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire cmd_start = i_wr && hit(i_addr, `OFS_COMMAND);
  wire busy = (state_ff != ST_IDLE);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // data registers are also loaded by a finished read
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      select_ff <= `RST_SELECT;
      cmd_write_ff <= 1'b0;
      address_ff <= `RST_ADDRESS;
      data_low_ff <= `RST_DATA_LOW;
      data_high_ff <= `RST_DATA_HIGH;
    end else begin
      if (i_wr && hit(i_addr, `OFS_SELECT)) begin
        select_ff <= i_wdata[`BIT_SEL_HI:`BIT_TEST_EN];
      end
      if (cmd_start) begin
        cmd_write_ff <= i_wdata[`BIT_CMD_WRITE];
      end
      if (i_wr && hit(i_addr, `OFS_ADDRESS)) begin
        address_ff <= i_wdata[`ADDR_MSB:0];
      end
      if (state_ff == ST_CAPTURE) begin
        data_low_ff <= ram_rdata[31:0];
        data_high_ff <= ram_rdata[36:32];
      end else begin
        if (i_wr && hit(i_addr, `OFS_DATA_LOW)) begin
          data_low_ff <= i_wdata;
        end
        if (i_wr && hit(i_addr, `OFS_DATA_HIGH)) begin
          data_high_ff <= i_wdata[`HIGH_MSB:0];
        end
      end
    end
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  // a command while busy starts no access but still loads cmd_write_ff; the ram is single ported
  always @* begin
    nxt_state = state_ff;
    ram_en = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (cmd_start) begin
          nxt_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        ram_en = 1'b1;
        nxt_state = cmd_write_ff ? ST_IDLE : ST_WAIT;
      end
      ST_WAIT: begin
        nxt_state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ram_bank #(.DEPTH(DEPTH), .AW(AW)) u_bank (
    .i_clk_sys(i_clk_sys),
    .i_test_mode(select_ff[`BIT_TEST_EN]),
    .i_en(ram_en),
    .i_wr(cmd_write_ff),
    .i_sel(select_ff[`BIT_SEL_HI:`BIT_SEL_LO]),
    .i_addr(address_ff[AW-1:0]),
    .i_wdata({data_high_ff, data_low_ff}),
    .o_rdata(ram_rdata)
  );

  // ----------------------------------------
  // outputs and read data
  // ----------------------------------------
  // ready drops the cycle after the command and returns once done
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0000_0000;
      o_test_mode <= 1'b0;
      o_port_ready <= 1'b1;
    end else begin
      o_test_mode <= select_ff[`BIT_TEST_EN];
      o_port_ready <= !(nxt_state != ST_IDLE);
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          `OFS_SELECT: o_rdata <= {!busy, 28'h000_0000, select_ff};
          `OFS_COMMAND: o_rdata <= {31'h0000_0000, cmd_write_ff};
          `OFS_ADDRESS: o_rdata <= {17'h0_0000, address_ff};
          `OFS_DATA_LOW: o_rdata <= data_low_ff;
          `OFS_DATA_HIGH: o_rdata <= {27'h000_0000, data_high_ff};
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // ram_test_port

// >>> verilog/test_ram.v
`timescale 1ns/1ps
// ----------------------------------------
// simple synchronous ram, one cycle read
// ----------------------------------------
module test_ram #(
  parameter WIDTH = 32,
  parameter DEPTH = 256,
  parameter AW = 8
) (
  input wire i_clk_sys,
  input wire i_en,
  input wire i_wr,
  input wire [AW-1:0] i_addr,
  input wire [WIDTH-1:0] i_wdata,
  output reg [WIDTH-1:0] o_rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // no reset on the array; contents are undefined until written
  always @(posedge i_clk_sys) begin
    if (i_en && i_wr) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_en && !i_wr) begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule // test_ram
